// file: hdl/dcdc_channel.sv
// One comparator channel: input synchroniser, noise filter and edge detector
`timescale 1ns/1ps
module dcdc_channel
  import dcdc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_hold,
  input wire logic i_raw,
  input wire logic [1:0] i_filter_sel,
  input wire logic i_both_edge,
  input wire logic i_polarity,
  input wire logic i_tick8,
  input wire logic i_tick32,
  output logic o_sync_level,
  output logic o_event
);
  logic [2:0] sync;
  logic [FILT_SAMPLES-1:0] samples;
  logic filt_level;
  logic prev_level;
  logic sample_en;
  logic eff_level;

  // Change accepted only when stages two and three agree
  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_hold) begin
      sync <= 3'h0;
      o_sync_level <= 1'b0;
    end else begin
      sync <= {sync[1:0], i_raw};
      if (sync[1] == sync[2]) begin
        o_sync_level <= sync[2];
      end
    end
  end

  always_comb begin
    case (i_filter_sel)
      FILT_DIV1: sample_en = 1'b1;
      FILT_DIV8: sample_en = i_tick8;
      FILT_DIV32: sample_en = i_tick32;
      default: sample_en = 1'b0;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_hold) begin
      samples <= '0;
      filt_level <= 1'b0;
    end else if (sample_en) begin
      samples <= {samples[FILT_SAMPLES-2:0], o_sync_level};
      if (&samples || ~|samples) begin
        filt_level <= samples[0];
      end
    end
  end

  // Filter off bypasses to the synchronised level
  assign eff_level = (i_filter_sel == FILT_OFF) ? o_sync_level : filt_level;

  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_hold) begin
      prev_level <= 1'b0;
      o_event <= 1'b0;
    end else begin
      prev_level <= eff_level;
      if (i_both_edge) begin
        o_event <= eff_level ^ prev_level;
      end else if (i_polarity) begin
        o_event <= prev_level & ~eff_level;
      end else begin
        o_event <= eff_level & ~prev_level;
      end
    end
  end

  // A hold clears the filter, so the cycle after a hold is not a filter decision
  chk_filter_three_equal: assert property (
    @(posedge i_core_clk) disable iff (i_rst || i_hold)
      $changed(filt_level) && !$past(i_rst || i_hold) |-> $past(&samples || ~|samples) && $past(sample_en))
    else $error("filter changed without stable run");

  chk_edge_polarity: assert property (
    @(posedge i_core_clk) disable iff (i_rst || i_hold)
      o_event |-> $past(i_both_edge) || ($past(eff_level) == ~$past(i_polarity)))
    else $error("event on wrong edge");

  chk_filter_bypass: assert property (
    @(posedge i_core_clk) disable iff (i_rst || i_hold)
      (i_filter_sel == FILT_OFF) && $rose(o_sync_level) && !i_both_edge && !i_polarity
        && ($past(i_filter_sel) == FILT_OFF) |=> o_event)
    else $error("unfiltered rise not seen");
endmodule : dcdc_channel

// file: hdl/dcdc_ctrl.sv
// Register file and control of the two-channel comparator
// Notes on behaviour
// - Comparator clock runs only while gate bit set
// - Gate low: reset, clear registers, ignore writes
// - System reset clears enable, mode, filter registers
// - Byte and single-bit writes both accepted
// - Mode register bit layout for both channels
// - Monitor flags are read-only
// - Monitor shows comparison result while enabled
// - Monitor undefined once channel disabled
// - Reference select: pin at 0, internal at 1
// - Per-channel compare enable bit
// - Filter passes level after three equal samples
// - Filter field: off, clk, clk/8, clk/32
// - Edge select: both, rising or falling
// - Filter settles within four sampling cycles
// - Raise event on selected effective edge
// - Forward event only while enable bit set
`timescale 1ns/1ps
module dcdc_ctrl
  import dcdc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_wr_byte,
  input wire logic i_wr_bit,
  input wire logic [2:0] i_bit_pos,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_chan0_cmp_out,
  input wire logic i_chan1_cmp_out,
  output logic o_comparator_clk_en,
  output logic o_comparator_rst,
  output logic o_chan0_compare_enable,
  output logic o_chan1_compare_enable,
  output logic o_chan0_reference_select,
  output logic o_chan1_reference_select,
  output logic [7:0] o_output_control,
  output logic o_chan0_compare_event,
  output logic o_chan1_compare_event
);
  logic [7:0] per_clk_en;
  logic [7:0] cmp_mode;
  logic [7:0] cmp_filt;
  logic [7:0] cmp_out_ctrl;
  logic gate;
  logic [DIV_W-1:0] div_cnt;
  logic tick8;
  logic tick32;
  logic [1:0] sync_level;
  logic [1:0] raw_event;
  logic [7:0] mode_view;
  logic [7:0] next_rdata;

  // Byte write replaces the masked bits, bit write touches one bit
  function automatic logic [7:0] apply_write(input logic [7:0] old, input logic [7:0] wmask,
                                             input logic byte_wr, input logic bit_wr,
                                             input logic [2:0] pos, input logic [7:0] data);
    logic [7:0] res;
    res = old;
    if (byte_wr) begin
      res = (old & ~wmask) | (data & wmask);
    end else if (bit_wr && wmask[pos]) begin
      res[pos] = data[0];
    end
    return res;
  endfunction : apply_write

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] target);
    return addr == target;
  endfunction : hit

  assign gate = per_clk_en[GATE_BIT];

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      per_clk_en <= PER_CLK_EN_RST;
    end else if (hit(i_addr, PER_CLK_EN_ADDR)) begin
      per_clk_en <= apply_write(per_clk_en, 8'hFF, i_wr_byte, i_wr_bit, i_bit_pos, i_wdata);
    end
  end

  // Comparator registers are held clear while the clock gate is off
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !gate) begin
      cmp_mode <= CMP_MODE_RST;
    end else if (hit(i_addr, CMP_MODE_ADDR)) begin
      cmp_mode <= apply_write(cmp_mode, CMP_MODE_WMASK, i_wr_byte, i_wr_bit, i_bit_pos, i_wdata);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || !gate) begin
      cmp_filt <= CMP_FILT_RST;
    end else if (hit(i_addr, CMP_FILT_ADDR)) begin
      cmp_filt <= apply_write(cmp_filt, 8'hFF, i_wr_byte, i_wr_bit, i_bit_pos, i_wdata);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || !gate) begin
      cmp_out_ctrl <= CMP_OUT_CTRL_RST;
    end else if (hit(i_addr, CMP_OUT_CTRL_ADDR)) begin
      cmp_out_ctrl <= apply_write(cmp_out_ctrl, CMP_OUT_CTRL_WMASK, i_wr_byte, i_wr_bit, i_bit_pos, i_wdata);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_comparator_clk_en <= 1'b0;
      o_comparator_rst <= 1'b1;
    end else begin
      o_comparator_clk_en <= gate;
      o_comparator_rst <= !gate;
    end
  end

  assign o_chan0_compare_enable = cmp_mode[CH0_EN_BIT];
  assign o_chan1_compare_enable = cmp_mode[CH1_EN_BIT];
  assign o_chan0_reference_select = cmp_mode[CH0_REF_BIT];
  assign o_chan1_reference_select = cmp_mode[CH1_REF_BIT];
  assign o_output_control = cmp_out_ctrl;

  // Divider free-runs so both channels share one phase
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      div_cnt <= '0;
      tick8 <= 1'b0;
      tick32 <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 5'h01;
      tick8 <= div_cnt[2:0] == DIV8_LAST[2:0];
      tick32 <= div_cnt == DIV32_LAST;
    end
  end

  dcdc_channel u_chan0 (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_hold(!gate || !cmp_mode[CH0_EN_BIT]),
    .i_raw(i_chan0_cmp_out),
    .i_filter_sel(cmp_filt[CH0_FCK_LO+1:CH0_FCK_LO]),
    .i_both_edge(cmp_filt[CH0_EDGE_BIT]),
    .i_polarity(cmp_filt[CH0_POL_BIT]),
    .i_tick8(tick8),
    .i_tick32(tick32),
    .o_sync_level(sync_level[0]),
    .o_event(raw_event[0])
  );

  dcdc_channel u_chan1 (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_hold(!gate || !cmp_mode[CH1_EN_BIT]),
    .i_raw(i_chan1_cmp_out),
    .i_filter_sel(cmp_filt[CH1_FCK_LO+1:CH1_FCK_LO]),
    .i_both_edge(cmp_filt[CH1_EDGE_BIT]),
    .i_polarity(cmp_filt[CH1_POL_BIT]),
    .i_tick8(tick8),
    .i_tick32(tick32),
    .o_sync_level(sync_level[1]),
    .o_event(raw_event[1])
  );

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_chan0_compare_event <= 1'b0;
      o_chan1_compare_event <= 1'b0;
    end else begin
      o_chan0_compare_event <= raw_event[0] && cmp_out_ctrl[CH0_IE_BIT];
      o_chan1_compare_event <= raw_event[1] && cmp_out_ctrl[CH1_IE_BIT];
    end
  end

  // Disabled channel reads zero; any value is allowed there
  always_comb begin
    mode_view = cmp_mode;
    mode_view[CH0_MON_BIT] = sync_level[0] && cmp_mode[CH0_EN_BIT];
    mode_view[CH1_MON_BIT] = sync_level[1] && cmp_mode[CH1_EN_BIT];
  end

  always_comb begin
    if (hit(i_addr, PER_CLK_EN_ADDR)) begin
      next_rdata = per_clk_en;
    end else if (hit(i_addr, CMP_MODE_ADDR)) begin
      next_rdata = mode_view;
    end else if (hit(i_addr, CMP_FILT_ADDR)) begin
      next_rdata = cmp_filt;
    end else if (hit(i_addr, CMP_OUT_CTRL_ADDR)) begin
      next_rdata = cmp_out_ctrl;
    end else begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end
  end

  chk_gate_holds_regs: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      !gate |=> (cmp_mode == 8'h00) && (cmp_filt == 8'h00) && (cmp_out_ctrl == 8'h00))
    else $error("comparator registers not held while gated");

  chk_clock_gate_on: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      i_wr_byte && hit(i_addr, PER_CLK_EN_ADDR) && i_wdata[GATE_BIT] |=> ##1 o_comparator_clk_en && !o_comparator_rst)
    else $error("clock not supplied after gate set");

  chk_reserved_zero: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      i_rd && hit(i_addr, CMP_MODE_ADDR) |=> !o_rdata[5] && !o_rdata[1])
    else $error("reserved mode bits read nonzero");

  chk_monitor_readonly: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      gate && i_wr_byte && hit(i_addr, CMP_MODE_ADDR) |=> !cmp_mode[CH0_MON_BIT] && !cmp_mode[CH1_MON_BIT])
    else $error("monitor bit stored a written value");

  chk_monitor_view: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      i_rd && hit(i_addr, CMP_MODE_ADDR) && cmp_mode[CH0_EN_BIT] |=> o_rdata[CH0_MON_BIT] == $past(sync_level[0]))
    else $error("monitor flag does not follow result");

  chk_event_gated: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      (o_chan0_compare_event |-> $past(cmp_out_ctrl[CH0_IE_BIT]) && $past(raw_event[0])))
    else $error("event forwarded while disabled");

  chk_divider_period: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      tick8 |=> !tick8 [*7] ##1 tick8)
    else $error("divide-by-8 pulse period wrong");

  chk_filter_write: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      gate && i_wr_bit && hit(i_addr, CMP_FILT_ADDR) |=> cmp_filt[$past(i_bit_pos)] == $past(i_wdata[0]))
    else $error("single-bit write not applied");

  chk_reset_clears: assert property (
    @(posedge i_core_clk)
      $past(i_rst) |-> (per_clk_en == PER_CLK_EN_RST) && (cmp_mode == CMP_MODE_RST) && (cmp_filt == CMP_FILT_RST))
    else $error("registers not cleared by reset");

  chk_gated_in_reset: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      !gate |=> o_comparator_rst && !o_comparator_clk_en)
    else $error("comparator not held in reset while gated");

  chk_clock_follows: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      gate |=> o_comparator_clk_en && !o_comparator_rst)
    else $error("comparator clock missing while gate set");

  chk_mode_byte_write: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      gate && i_wr_byte && hit(i_addr, CMP_MODE_ADDR) |=> cmp_mode == ($past(i_wdata) & CMP_MODE_WMASK))
    else $error("mode byte write not applied");

  chk_filter_byte_write: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      gate && i_wr_byte && hit(i_addr, CMP_FILT_ADDR) |=> cmp_filt == $past(i_wdata))
    else $error("filter byte write not applied");

  // Bit write must leave the neighbouring bits alone
  chk_filter_bit_only: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      gate && i_wr_bit && !i_wr_byte && hit(i_addr, CMP_FILT_ADDR)
        |=> ((cmp_filt ^ $past(cmp_filt)) & ~(8'h01 << $past(i_bit_pos))) == 8'h00)
    else $error("bit write disturbed other bits");

  chk_monitor_view_ch1: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      i_rd && hit(i_addr, CMP_MODE_ADDR) && cmp_mode[CH1_EN_BIT] |=> o_rdata[CH1_MON_BIT] == $past(sync_level[1]))
    else $error("channel 1 monitor flag does not follow result");

  chk_event_blocked: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      !cmp_out_ctrl[CH1_IE_BIT] |=> !o_chan1_compare_event)
    else $error("channel 1 event passed while disabled");

  chk_event_forwarded: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      raw_event[1] && cmp_out_ctrl[CH1_IE_BIT] |=> o_chan1_compare_event)
    else $error("enabled channel 1 event was lost");

  // Both rates come from one counter, so the slow tick lands on a fast one
  chk_tick32_period: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
      tick32 |-> tick8 ##32 tick32)
    else $error("divide-by-32 pulse period wrong");
endmodule : dcdc_ctrl

// file: pkg/dcdc_pkg.sv
// Constants shared by the dual comparator control block
package dcdc_pkg;
  localparam int ADDR_W = 20;
  localparam logic [19:0] PER_CLK_EN_ADDR = 20'hF00F0;
  localparam logic [19:0] CMP_MODE_ADDR = 20'hFFF60;
  localparam logic [19:0] CMP_FILT_ADDR = 20'hFFF61;
  localparam logic [19:0] CMP_OUT_CTRL_ADDR = 20'hFFF62;
  localparam logic [7:0] PER_CLK_EN_RST = 8'h00;
  localparam logic [7:0] CMP_MODE_RST = 8'h00;
  localparam logic [7:0] CMP_FILT_RST = 8'h00;
  localparam logic [7:0] CMP_OUT_CTRL_RST = 8'h00;
  // Writable bits: monitor and reserved bits never store
  localparam logic [7:0] CMP_MODE_WMASK = 8'h55;
  localparam logic [7:0] CMP_OUT_CTRL_WMASK = 8'hF7;
  localparam int GATE_BIT = 6;
  localparam int CH1_MON_BIT = 7;
  localparam int CH1_REF_BIT = 6;
  localparam int CH1_EN_BIT = 4;
  localparam int CH0_MON_BIT = 3;
  localparam int CH0_REF_BIT = 2;
  localparam int CH0_EN_BIT = 0;
  localparam int CH1_EDGE_BIT = 7;
  localparam int CH1_POL_BIT = 6;
  localparam int CH1_FCK_LO = 4;
  localparam int CH0_EDGE_BIT = 3;
  localparam int CH0_POL_BIT = 2;
  localparam int CH0_FCK_LO = 0;
  localparam int CH1_IE_BIT = 4;
  localparam int CH0_IE_BIT = 0;
  localparam logic [1:0] FILT_OFF = 2'h0;
  localparam logic [1:0] FILT_DIV1 = 2'h1;
  localparam logic [1:0] FILT_DIV8 = 2'h2;
  localparam logic [1:0] FILT_DIV32 = 2'h3;
  localparam int DIV_W = 5;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1F;
  localparam int FILT_SAMPLES = 3;
endpackage : dcdc_pkg

// file: testbench/dcdc_analog_model.sv
// Behavioural pair of analog comparator cores facing the control block
`timescale 1ns/1ps
module dcdc_analog_model #(
  parameter int INT_REF_MV = 815
) (
  input wire logic i_en0,
  input wire logic i_en1,
  input wire logic i_sel0,
  input wire logic i_sel1,
  input wire logic [11:0] i_vin0,
  input wire logic [11:0] i_vin1,
  input wire logic [11:0] i_vref0,
  input wire logic [11:0] i_vref1,
  output logic o_out0,
  output logic o_out1
);
  logic [11:0] ref0;
  logic [11:0] ref1;
  assign ref0 = i_sel0 ? 12'(INT_REF_MV) : i_vref0;
  assign ref1 = i_sel1 ? 12'(INT_REF_MV) : i_vref1;
  // A stopped core is not trustworthy, so it shows the wrong level
  assign o_out0 = (i_vin0 > ref0) ^ ~i_en0;
  assign o_out1 = (i_vin1 > ref1) ^ ~i_en1;
endmodule : dcdc_analog_model

// file: testbench/tb_dual_comparator_digital_control.sv
// Self-checking bench for the dual comparator control block
`timescale 1ns/1ps
module tb_dual_comparator_digital_control;
  import dcdc_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic [19:0] addr = '0;
  logic wr_byte = 0;
  logic wr_bit = 0;
  logic [2:0] bit_pos = '0;
  logic [7:0] wdata = '0;
  logic rd = 0;
  logic [7:0] rdata;
  logic [7:0] ocr;
  logic [11:0] vin0 = 12'h12C;
  logic [11:0] vin1 = 12'h12C;
  logic c0, c1, en0, en1, sel0, sel1, clk_en, crst, ev0, ev1;
  int n_fail = 0;
  int total_checks = 0;
  int cnt0 = 0;
  int cnt1 = 0;
  int m_reg [4] = '{0, 0, 0, 0};
  int msk [4] = '{255, 85, 255, 247};
  logic [19:0] addrs [4] = '{PER_CLK_EN_ADDR, CMP_MODE_ADDR, CMP_FILT_ADDR, CMP_OUT_CTRL_ADDR};
  logic [7:0] fe [4] = '{8'h00, 8'h44, 8'h88, 8'h88};
  int er [4] = '{1, 0, 1, 0};
  int ea [4] = '{1, 1, 2, 0};
  int gw [4] = '{3, 2, 12, 40};

  initial begin
    forever #25 clk = ~clk;
  end

  dcdc_ctrl u_dut (.i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_wr_byte(wr_byte), .i_wr_bit(wr_bit),
    .i_bit_pos(bit_pos), .i_wdata(wdata), .i_rd(rd), .o_rdata(rdata), .i_chan0_cmp_out(c0),
    .i_chan1_cmp_out(c1), .o_comparator_clk_en(clk_en), .o_comparator_rst(crst),
    .o_chan0_compare_enable(en0), .o_chan1_compare_enable(en1), .o_chan0_reference_select(sel0),
    .o_chan1_reference_select(sel1), .o_output_control(ocr), .o_chan0_compare_event(ev0),
    .o_chan1_compare_event(ev1));

  dcdc_analog_model u_ana (.i_en0(en0), .i_en1(en1), .i_sel0(sel0), .i_sel1(sel1), .i_vin0(vin0),
    .i_vin1(vin1), .i_vref0(12'h1F4), .i_vref1(12'h1F4), .o_out0(c0), .o_out1(c1));

  always @(posedge clk) begin
    if (ev0 === 1'b1) cnt0++;
    if (ev1 === 1'b1) cnt1++;
  end

  function automatic int idx(input logic [19:0] a);
    for (int i = 0; i < 4; i++) if (addrs[i] == a) return i;
    return -1;
  endfunction : idx

  // Reference copy of the register file
  task automatic mwr(input logic [19:0] a, input int d);
    int i;
    i = idx(a);
    if (i == 0 || (i > 0 && m_reg[0][6])) m_reg[i] = d & msk[i];
    if (!m_reg[0][6]) for (int k = 1; k < 4; k++) m_reg[k] = 0;
  endtask : mwr

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_byte <= 1'b1;
    @(posedge clk);
    wr_byte <= 1'b0;
    mwr(a, int'(d));
  endtask : wr

  task automatic wbit(input logic [19:0] a, input logic [2:0] p, input logic v);
    int i;
    int d;
    i = idx(a);
    d = (i < 0) ? 0 : m_reg[i];
    d[p] = v;
    @(posedge clk);
    addr <= a;
    bit_pos <= p;
    wdata <= {7'h00, v};
    wr_bit <= 1'b1;
    @(posedge clk);
    wr_bit <= 1'b0;
    mwr(a, d);
  endtask : wbit

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task automatic rchk(input logic [19:0] a, input logic [7:0] mk, input logic [7:0] mon);
    int i;
    logic [7:0] e;
    i = idx(a);
    e = (i < 0) ? 8'h00 : 8'(m_reg[i]);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read data", (e | mon) & mk, rdata & mk);
  endtask : rchk

  // Event enable stays off while edge or filter settings move
  task automatic setup(input logic [7:0] f, input logic [7:0] ie);
    wr(CMP_OUT_CTRL_ADDR, 8'h00);
    wr(CMP_FILT_ADDR, f);
    repeat (200) @(posedge clk);
    cnt0 = 0;
    cnt1 = 0;
    wr(CMP_OUT_CTRL_ADDR, ie);
    #1;
    chk("output control", 8'(m_reg[3]), ocr);
  endtask : setup

  task automatic pulse(input int w, input int eh, input int eall);
    @(posedge clk);
    vin0 <= 12'h3E8;
    vin1 <= 12'h3E8;
    #1;
    cnt0 = 0;
    cnt1 = 0;
    repeat (w) @(posedge clk);
    vin0 <= 12'h12C;
    vin1 <= 12'h12C;
    #1;
    chk("events ch0 high", 8'(eh), 8'(cnt0));
    chk("events ch1 high", 8'(eh), 8'(cnt1));
    repeat (250) @(posedge clk);
    #1;
    chk("events ch0 all", 8'(eall), 8'(cnt0));
    chk("events ch1 all", 8'(eall), 8'(cnt1));
  endtask : pulse

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    results();
  end

  initial begin
    void'($urandom(68548));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("clock enable", 8'h00, {7'h00, clk_en});
    chk("held in reset", 8'h01, {7'h00, crst});
    for (int a = 0; a < 4; a++) rchk(addrs[a], 8'hFF, 8'h00);
    wr(CMP_MODE_ADDR, 8'h11);
    rchk(CMP_MODE_ADDR, 8'hFF, 8'h00);
    wbit(PER_CLK_EN_ADDR, 3'd6, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk("clock enable", 8'h01, {7'h00, clk_en});
    chk("held in reset", 8'h00, {7'h00, crst});
    for (int k = 0; k < 24; k++) begin
      int j;
      j = 1 + ($urandom % 3);
      if (k[0]) wbit(addrs[j], 3'($urandom), 1'($urandom));
      else wr(addrs[j], 8'($urandom));
      rchk(addrs[j], (j == 1) ? 8'h77 : 8'hFF, 8'h00);
    end
    // Reset again with the gate bit set and the mode, filter and output control registers holding random contents
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++) m_reg[k] = 0;
    #1;
    chk("clock enable", 8'h00, {7'h00, clk_en});
    chk("held in reset", 8'h01, {7'h00, crst});
    for (int a = 0; a < 4; a++) rchk(addrs[a], 8'hFF, 8'h00);
    wr(20'hFFF70, 8'hA5);
    rchk(20'hFFF70, 8'hFF, 8'h00);
    wr(PER_CLK_EN_ADDR, 8'h00);
    wr(PER_CLK_EN_ADDR, 8'h40);
    for (int a = 1; a < 4; a++) rchk(addrs[a], 8'hFF, 8'h00);
    wr(CMP_MODE_ADDR, 8'h51);
    vin0 <= 12'h258;
    vin1 <= 12'h258;
    repeat (8) @(posedge clk);
    rchk(CMP_MODE_ADDR, 8'hFF, 8'h08);
    wr(CMP_MODE_ADDR, 8'h15);
    repeat (8) @(posedge clk);
    rchk(CMP_MODE_ADDR, 8'hFF, 8'h80);
    chk("routing", 8'h07, {4'h0, sel1, sel0, en1, en0});
    wr(CMP_MODE_ADDR, 8'h10);
    repeat (8) @(posedge clk);
    rchk(CMP_MODE_ADDR, 8'hF7, 8'h80);
    vin0 <= 12'h12C;
    vin1 <= 12'h12C;
    wr(CMP_MODE_ADDR, 8'h51);
    for (int m = 0; m < 4; m++) begin
      setup(fe[m], (m == 3) ? 8'h00 : 8'h11);
      pulse(250, er[m], ea[m]);
    end
    for (int f = 0; f < 4; f++) begin
      setup(8'(8'h88 + f * 8'h11), 8'h11);
      pulse(gw[f], 0, (f == 0) ? 2 : 0);
      pulse(250, 1, 2);
    end
    results();
  end
endmodule : tb_dual_comparator_digital_control
